// File: verilog/dsl_pkg.sv
package dsl_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ         = 40_000_000;
	localparam int FLASH_HALF_MS  = 500;
	localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;

	// ----------------------------------------------------------------
	// Error memory and reset values
	// ----------------------------------------------------------------
	localparam int          HIST_DEPTH = 10;
	localparam logic [15:0] NO_ERROR   = 16'h0000;
	localparam logic [15:0] ASW_RESET  = 16'h0000;

	// Action state word bit positions
	localparam int ASW_WARN  = 0;
	localparam int ASW_QSTOP = 1;
	localparam int ASW_FAULT = 2;
	localparam int ASW_FATAL = 3;
	localparam int ASW_ASYNC = 4;

	// Operating state codes shown on the LEDs
	localparam logic [3:0] OP_START   = 4'h1;
	localparam logic [3:0] OP_QSTOP   = 4'h7;
	localparam logic [3:0] OP_FAULT   = 4'h9;
	localparam logic [3:0] OP_NO_FW   = 4'ha;
	localparam logic [3:0] OP_INT_ERR = 4'hb;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CL_WARN      = 3'h0,
		CL_QSTOP7    = 3'h1,
		CL_QSTOP9    = 3'h2,
		CL_FATAL_ACK = 3'h3,
		CL_FATAL_NAK = 3'h4
	} dsl_class_t;

	typedef enum logic [2:0] {
		RSP_OK      = 3'h0,
		RSP_EXEC    = 3'h1,
		RSP_RANGE   = 3'h2,
		RSP_INVALID = 3'h3,
		RSP_UNKNOWN = 3'h4
	} dsl_rsp_t;

	typedef struct packed {logic green; logic red;} dsl_led_t;
	typedef struct packed {logic [15:0] num; dsl_class_t cls;} dsl_entry_t;
	typedef struct packed {logic valid; logic [15:0] num; dsl_class_t cls;} dsl_err_t;
	typedef struct packed {
		logic valid;
		logic known;
		logic inRange;
		logic execFail;
		logic invalid;
	} dsl_cmd_t;
	typedef struct packed {logic valid; logic err; dsl_rsp_t code;} dsl_reply_t;
	typedef struct packed {
		logic powerGood;
		logic selfTest;
		logic configured;
		logic recoverable;
		logic unrecoverable;
		logic noFirmware;
		logic internalErr;
	} dsl_dev_t;
	typedef struct packed {
		logic hasIp;
		logic connUp;
		logic toutEvt;
		logic toutClear;
		logic dupIp;
	} dsl_net_t;

endpackage

// File: verilog/dsl_blink.sv
module dsl_blink
	import dsl_pkg::*;
#(
	parameter int HALF_CYC = FLASH_HALF_CYC
)(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Flash phase
	output logic      phase
);

	localparam int HW = $clog2(HALF_CYC + 1);

	typedef struct packed {
		logic [HW-1:0] cnt;
		logic          phase;
	} dsl_blink_t;

	dsl_blink_t s;
	dsl_blink_t next_s;

	// Divider: phase flips on each terminal count
	always_comb
	begin
		next_s = s;
		if (s.cnt == HW'(HALF_CYC - 1))
		begin
			next_s.cnt   = '0;
			next_s.phase = ~s.phase;
		end
		else
			next_s.cnt = s.cnt + 1'b1;
	end

	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign phase = s.phase;

endmodule

// File: verilog/dsl_top.sv
module dsl_top
	import dsl_pkg::*;
#(
	parameter int DEPTH    = HIST_DEPTH,
	parameter int HALF_CYC = FLASH_HALF_CYC
)(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Asynchronous error events and acknowledge
	input  dsl_err_t         asyncErr,
	input  wire logic        errReset,
	input  wire logic [3:0]  driveState,
	// Error memory access
	input  wire logic        histClear,
	input  wire logic        histRewind,
	input  wire logic        histRead,
	output logic [15:0]      histRdNum,
	output dsl_class_t       histRdClass,
	output logic             histRdValid,
	// Fieldbus command check
	input  dsl_cmd_t         cmd,
	output dsl_reply_t       reply,
	// Error state
	output logic [15:0]      lastStopCause,
	output logic [15:0]      actionStateWord,
	output logic             quickStopReq,
	output logic             faultReq,
	output logic [3:0]       opCode,
	// Status inputs and LEDs
	input  dsl_dev_t         dev,
	input  dsl_net_t         net,
	output dsl_led_t         devLed,
	output dsl_led_t         netLed
);

	localparam int CW = $clog2(DEPTH + 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		dsl_entry_t [DEPTH-1:0] hist;
		logic [CW-1:0]          count;
		logic [CW-1:0]          rdPtr;
		logic [15:0]            rdNum;
		dsl_class_t             rdClass;
		logic                   rdValid;
		logic [15:0]            lastCause;
		logic [15:0]            asw;
		logic                   faultHold;
		logic                   fatalHold;
		logic                   qsReq;
		logic                   ftReq;
		logic [3:0]             op;
		dsl_reply_t             rsp;
		logic                   toutHold;
		dsl_led_t               dLed;
		dsl_led_t               nLed;
	} dsl_state_t;

	dsl_state_t s;
	dsl_state_t next_s;
	logic       phase;

	// Flash phase source
	dsl_blink #(
		.HALF_CYC (HALF_CYC)
	) u_blink (
		.clk   (clk),
		.rst   (rst),
		.phase (phase)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.rdValid   = 1'b0;
		next_s.qsReq     = 1'b0;
		next_s.ftReq     = 1'b0;
		next_s.rsp.valid = 1'b0;

		// Error memory clear and read pointer rewind
		if (histClear)
		begin
			next_s.count = '0;
			next_s.rdPtr = '0;
		end
		if (histRewind)
			next_s.rdPtr = '0;

		// Sequential read, zero past the last entry
		if (histRead)
		begin
			next_s.rdValid = 1'b1;
			if (s.rdPtr < s.count)
			begin
				next_s.rdNum   = s.hist[s.rdPtr].num;
				next_s.rdClass = s.hist[s.rdPtr].cls;
				next_s.rdPtr   = s.rdPtr + 1'b1;
			end
			else
			begin
				next_s.rdNum   = NO_ERROR;
				next_s.rdClass = CL_WARN;
			end
		end

		// Acknowledge; a class four error ignores it
		if (errReset && !s.fatalHold)
		begin
			next_s.lastCause = NO_ERROR;
			next_s.asw       = ASW_RESET;
			next_s.faultHold = 1'b0;
		end

		// New error wins over clear in the same cycle
		if (asyncErr.valid)
		begin
			// Oldest entry drops out once full
			if (next_s.count == CW'(DEPTH))
			begin
				for (int i = 0; i < DEPTH - 1; i++)
					next_s.hist[i] = next_s.hist[i + 1];
				next_s.hist[DEPTH-1] = {asyncErr.num, asyncErr.cls};
			end
			else
			begin
				next_s.hist[next_s.count] = {asyncErr.num, asyncErr.cls};
				next_s.count = next_s.count + 1'b1;
			end
			// Only the triggering cause is kept
			if (next_s.lastCause == NO_ERROR)
				next_s.lastCause = asyncErr.num;
			next_s.asw[ASW_ASYNC] = 1'b1;
			unique case (asyncErr.cls)
				CL_WARN:
					next_s.asw[ASW_WARN] = 1'b1;
				CL_QSTOP7, CL_QSTOP9:
				begin
					next_s.asw[ASW_QSTOP] = 1'b1;
					next_s.qsReq          = 1'b1;
				end
				CL_FATAL_ACK:
				begin
					next_s.asw[ASW_FAULT] = 1'b1;
					next_s.faultHold      = 1'b1;
					next_s.ftReq          = 1'b1;
				end
				CL_FATAL_NAK:
				begin
					next_s.asw[ASW_FAULT] = 1'b1;
					next_s.asw[ASW_FATAL] = 1'b1;
					next_s.faultHold      = 1'b1;
					next_s.fatalHold      = 1'b1;
					next_s.ftReq          = 1'b1;
				end
				default:
					next_s.asw[ASW_WARN] = 1'b1;
			endcase
		end

		// Synchronous error reply, most specific cause first
		if (cmd.valid)
		begin
			next_s.rsp.valid = 1'b1;
			next_s.rsp.err   = 1'b1;
			if (!cmd.known)
				next_s.rsp.code = RSP_UNKNOWN;
			else if (cmd.invalid)
				next_s.rsp.code = RSP_INVALID;
			else if (!cmd.inRange)
				next_s.rsp.code = RSP_RANGE;
			else if (cmd.execFail)
				next_s.rsp.code = RSP_EXEC;
			else
			begin
				next_s.rsp.code = RSP_OK;
				next_s.rsp.err  = 1'b0;
			end
		end

		// Operating state code for the LEDs
		if (dev.internalErr)
			next_s.op = OP_INT_ERR;
		else if (dev.noFirmware)
			next_s.op = OP_NO_FW;
		else if (s.faultHold)
			next_s.op = OP_FAULT;
		else
			next_s.op = driveState;

		// Timeout stays until all are re-established; set wins
		if (net.toutClear)
			next_s.toutHold = 1'b0;
		if (net.toutEvt)
			next_s.toutHold = 1'b1;

		// Device status LED
		if (!dev.powerGood)
			next_s.dLed = '{green: 1'b0, red: 1'b0};
		else if (dev.selfTest)
			next_s.dLed = '{green: phase, red: ~phase};
		else if (dev.unrecoverable || s.fatalHold)
			next_s.dLed = '{green: 1'b0, red: 1'b1};
		else if (dev.recoverable)
			next_s.dLed = '{green: 1'b0, red: phase};
		else if (!dev.configured)
			next_s.dLed = '{green: phase, red: 1'b0};
		else
			next_s.dLed = '{green: 1'b1, red: 1'b0};

		// Network status LED, most severe first
		if (!dev.powerGood)
			next_s.nLed = '{green: 1'b0, red: 1'b0};
		else if (dev.selfTest)
			next_s.nLed = '{green: phase, red: ~phase};
		else if (net.dupIp)
			next_s.nLed = '{green: 1'b0, red: 1'b1};
		else if (s.toutHold)
			next_s.nLed = '{green: 1'b0, red: phase};
		else if (net.connUp)
			next_s.nLed = '{green: phase, red: 1'b0};
		else if (net.hasIp)
			next_s.nLed = '{green: 1'b1, red: 1'b0};
		else
			next_s.nLed = '{green: 1'b0, red: 1'b0};
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s           <= '0;
			s.lastCause <= NO_ERROR;
			s.asw       <= ASW_RESET;
			s.op        <= OP_START;
		end
		else
			s <= next_s;
	end

	// Outputs straight from the state
	assign histRdNum       = s.rdNum;
	assign histRdClass     = s.rdClass;
	assign histRdValid     = s.rdValid;
	assign reply           = s.rsp;
	assign lastStopCause   = s.lastCause;
	assign actionStateWord = s.asw;
	assign quickStopReq    = s.qsReq;
	assign faultReq        = s.ftReq;
	assign opCode          = s.op;
	assign devLed          = s.dLed;
	assign netLed          = s.nLed;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_hist_bound;
		s.count <= CW'(DEPTH);
	endproperty
	a_hist_bound: assert property (p_hist_bound)
		else $error("error memory holds more than its depth");

	property p_read_empty;
		histRead && !histClear && !histRewind && (s.rdPtr >= s.count)
			|=> histRdValid && (histRdNum == NO_ERROR);
	endproperty
	a_read_empty: assert property (p_read_empty)
		else $error("read past last entry not zero");

	property p_qstop;
		asyncErr.valid && (asyncErr.cls inside {CL_QSTOP7, CL_QSTOP9})
			|=> quickStopReq && !faultReq ##1
			(!quickStopReq || $past(asyncErr.valid && (asyncErr.cls inside {CL_QSTOP7, CL_QSTOP9})));
	endproperty
	a_qstop: assert property (p_qstop)
		else $error("quick stop request missing or long");

	property p_fault;
		asyncErr.valid && (asyncErr.cls inside {CL_FATAL_ACK, CL_FATAL_NAK})
			|=> faultReq ##1
			(opCode == OP_FAULT || $past(dev.internalErr) || $past(dev.noFirmware));
	endproperty
	a_fault: assert property (p_fault)
		else $error("fault response missing");

	property p_first_cause;
		asyncErr.valid && (lastStopCause == NO_ERROR) && !errReset
			|=> (lastStopCause == $past(asyncErr.num)) && actionStateWord[ASW_ASYNC];
	endproperty
	a_first_cause: assert property (p_first_cause)
		else $error("last cause not taken from first error");

	property p_keep_cause;
		(lastStopCause != NO_ERROR) && !errReset && !histClear
			|=> $stable(lastStopCause);
	endproperty
	a_keep_cause: assert property (p_keep_cause)
		else $error("last cause overwritten by later error");

	property p_unknown;
		cmd.valid && !cmd.known |=> reply.valid && reply.err && (reply.code == RSP_UNKNOWN);
	endproperty
	a_unknown: assert property (p_unknown)
		else $error("unknown parameter not reported");

	property p_clear_zero;
		errReset && !s.fatalHold && !asyncErr.valid |=> (lastStopCause == NO_ERROR);
	endproperty
	a_clear_zero: assert property (p_clear_zero)
		else $error("last cause not zero after acknowledge");

	property p_fatal_stays;
		s.fatalHold |=> s.fatalHold && (lastStopCause != NO_ERROR);
	endproperty
	a_fatal_stays: assert property (p_fatal_stays)
		else $error("class four error cleared without power cycle");

	property p_self_test;
		dev.powerGood && dev.selfTest
			|=> (devLed.green != devLed.red) && (netLed == devLed);
	endproperty
	a_self_test: assert property (p_self_test)
		else $error("self-test not alternating on both LEDs");

	property p_dup_ip;
		dev.powerGood && !dev.selfTest && net.dupIp |=> netLed.red && !netLed.green;
	endproperty
	a_dup_ip: assert property (p_dup_ip)
		else $error("duplicate address not steady red");

	property p_tout_hold;
		s.toutHold && !net.toutClear |=> s.toutHold;
	endproperty
	a_tout_hold: assert property (p_tout_hold)
		else $error("timeout indication dropped early");

	property p_unpowered;
		!dev.powerGood |=> (devLed == '0) && (netLed == '0);
	endproperty
	a_unpowered: assert property (p_unpowered)
		else $error("LED lit while unpowered");

endmodule

// File: verification/dsl_master_model.sv
module dsl_master_model
	import dsl_pkg::*;
(
	// Clock
	input  wire logic        clk,
	// Command check
	output dsl_cmd_t         cmd,
	input  wire dsl_reply_t  reply,
	// Error memory
	output logic             histClear,
	output logic             histRewind,
	output logic             histRead,
	input  wire logic [15:0] histRdNum,
	input  wire dsl_class_t  histRdClass,
	input  wire logic        histRdValid
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// Fieldbus master requests
	// ----------------------------------------------------------------
	// Idle at time zero
	initial
	begin
		cmd = '0;
		histClear = 1'b0;
		histRewind = 1'b0;
		histRead = 1'b0;
	end

	// One command, reply taken one edge later; last drops valid
	task send(input dsl_cmd_t c, input bit last, output dsl_reply_t r);
		cmd = c;
		@(posedge clk);
		#1;
		r = reply;
		if (last)
			cmd = '0;
	endtask

	// Clear or rewind pulse
	task hist(input logic clr, input logic rew);
		histClear = clr;
		histRewind = rew;
		@(posedge clk);
		#1;
		histClear = 1'b0;
		histRewind = 1'b0;
	endtask

	// Sequential read; more keeps the strobe up for the next one
	task read(input bit more, output logic [15:0] n, output dsl_class_t c, output logic v);
		if (!histRead)
			histRead = 1'b1;
		@(posedge clk);
		#1;
		n = histRdNum;
		c = histRdClass;
		v = histRdValid;
		if (!more)
			histRead = 1'b0;
	endtask
endmodule

// File: verification/dsl_top_tb.sv
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("FAIL %s expected %h seen %h", nm, e, g); end end

module dsl_top_tb
	import dsl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam logic [4:0] L_OFF = 5'h00;
	localparam logic [4:0] L_GRN = 5'h19;
	localparam logic [4:0] L_GFL = 5'h10;
	localparam logic [4:0] L_RED = 5'h07;
	localparam logic [4:0] L_RFL = 5'h04;
	localparam logic [4:0] L_ALT = 5'h15;

	logic        clk;
	logic        rst;
	dsl_err_t    asyncErr;
	logic        errReset;
	logic [3:0]  driveState;
	dsl_cmd_t    cmd;
	dsl_reply_t  reply;
	logic        histClear;
	logic        histRewind;
	logic        histRead;
	logic [15:0] histRdNum;
	dsl_class_t  histRdClass;
	logic        histRdValid;
	logic [15:0] lastStopCause;
	logic [15:0] actionStateWord;
	logic        quickStopReq;
	logic        faultReq;
	logic [3:0]  opCode;
	dsl_dev_t    dev;
	dsl_net_t    net;
	dsl_led_t    devLed;
	dsl_led_t    netLed;
	int          n_fail;
	int          n_tests;

	// ----------------------------------------------------------------
	// Design and fieldbus master
	// ----------------------------------------------------------------
	dsl_top #(.DEPTH(HIST_DEPTH), .HALF_CYC(4)) dut (
		.clk(clk), .rst(rst), .asyncErr(asyncErr), .errReset(errReset),
		.driveState(driveState), .histClear(histClear), .histRewind(histRewind),
		.histRead(histRead), .histRdNum(histRdNum), .histRdClass(histRdClass),
		.histRdValid(histRdValid), .cmd(cmd), .reply(reply),
		.lastStopCause(lastStopCause), .actionStateWord(actionStateWord),
		.quickStopReq(quickStopReq), .faultReq(faultReq), .opCode(opCode),
		.dev(dev), .net(net), .devLed(devLed), .netLed(netLed));

	dsl_master_model m (
		.clk(clk), .cmd(cmd), .reply(reply), .histClear(histClear),
		.histRewind(histRewind), .histRead(histRead), .histRdNum(histRdNum),
		.histRdClass(histRdClass), .histRdValid(histRdValid));

	// 40 MHz clock
	initial
		clk = 1'b0;
	always #12.5 clk = ~clk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Error event; more keeps valid up for a back-to-back event
	task err(input logic [15:0] n, input dsl_class_t c, input bit more);
		asyncErr = '{1'b1, n, c};
		tick(1);
		if (!more)
			asyncErr = '0;
	endtask

	task ack();
		errReset = 1'b1;
		tick(1);
		errReset = 1'b0;
		tick(1);
	endtask

	task pulse_rst();
		rst = 1'b1;
		tick(1);
		rst = 1'b0;
		tick(2);
	endtask

	// Watch one LED for two flash periods: {gAny,gAll,rAny,rAll,alternating}
	task ledchk(input bit isNet, input logic [4:0] e);
		logic     gO, gA, rO, rA, alt;
		dsl_led_t l;
		gO = 0; gA = 1; rO = 0; rA = 1; alt = 1;
		tick(2);
		repeat (16)
		begin
			l = isNet ? netLed : devLed;
			gO |= l.green; gA &= l.green; rO |= l.red; rA &= l.red; alt &= l.green ^ l.red;
			tick(1);
		end
		`CHK(isNet ? "netLed" : "devLed", e, {gO, gA, rO, rA, alt})
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_async();
		err(16'h1234, CL_QSTOP7, 0);
		`CHK("quickStopReq", 1'b1, quickStopReq)
		`CHK("lastStopCause", 16'h1234, lastStopCause)
		`CHK("actionStateWord", 16'h0012, actionStateWord)
		err(16'h0055, CL_FATAL_ACK, 0);
		`CHK("faultReq", 1'b1, faultReq)
		`CHK("quickStopReq", 1'b0, quickStopReq)
		`CHK("lastStopCause", 16'h1234, lastStopCause)
		`CHK("actionStateWord", 16'h0016, actionStateWord)
		tick(1);
		`CHK("opCode", OP_FAULT, opCode)
		ack();
		`CHK("lastStopCause", NO_ERROR, lastStopCause)
		`CHK("opCode", 4'h6, opCode)
		dev = 7'h50;
		err(16'h0077, CL_FATAL_NAK, 0);
		`CHK("faultReq", 1'b1, faultReq)
		ack();
		`CHK("opCode", OP_FAULT, opCode)
		`CHK("class4 bit", 1'b1, actionStateWord[ASW_FATAL])
		ledchk(0, L_RED);
		pulse_rst();
		`CHK("opCode", 4'h6, opCode)
		dev = 7'h51;
		tick(2);
		`CHK("opCode", OP_INT_ERR, opCode)
		dev = 7'h52;
		tick(2);
		`CHK("opCode", OP_NO_FW, opCode)
		dev = 7'h50;
		driveState = 4'h4;
		tick(2);
		`CHK("opCode", 4'h4, opCode)
		driveState = 4'h6;
		err(16'h0099, CL_QSTOP9, 0);
		`CHK("quickStopReq", 1'b1, quickStopReq)
		`CHK("actionStateWord", 16'h0012, actionStateWord)
		err(16'h00aa, CL_WARN, 0);
		`CHK("quickStopReq", 1'b0, quickStopReq)
		`CHK("actionStateWord", 16'h0013, actionStateWord)
		`CHK("lastStopCause", 16'h0099, lastStopCause)
		ack();
		`CHK("lastStopCause", NO_ERROR, lastStopCause)
	endtask

	task t_sync();
		logic [4:0] cin [6];
		dsl_rsp_t   ex [6];
		dsl_reply_t r;
		cin = '{5'h11, 5'h1f, 5'h1a, 5'h1e, 5'h1c, 5'h18};
		ex = '{RSP_UNKNOWN, RSP_INVALID, RSP_RANGE, RSP_EXEC, RSP_OK, RSP_RANGE};
		for (int i = 0; i < 6; i++)
		begin
			m.send(cin[i], i == 5, r);
			`CHK("reply", {1'b1, ex[i] != RSP_OK, ex[i]}, r)
		end
		tick(1);
		`CHK("reply held", {1'b0, 1'b1, RSP_RANGE}, reply)
	endtask

	task t_hist();
		logic [15:0] n;
		dsl_class_t  c;
		logic        v;
		m.hist(1, 0);
		for (int i = 1; i <= 11; i++)
			err(i[15:0], i[0] ? CL_QSTOP7 : CL_WARN, i < 11);
		m.hist(0, 1);
		for (int i = 2; i <= 12; i++)
		begin
			m.read(i < 12, n, c, v);
			`CHK("histRdNum", (i <= 11) ? i[15:0] : 16'h0000, n)
			`CHK("histRdValid", 1'b1, v)
			`CHK("histRdClass", (i <= 11 && i[0]) ? CL_QSTOP7 : CL_WARN, c)
		end
		`CHK("histRdClass", CL_WARN, histRdClass)
		ack();
	endtask

	task t_leds();
		dev = 7'h00;
		net = 5'h10;
		ledchk(0, L_OFF);
		ledchk(1, L_OFF);
		dev = 7'h60;
		ledchk(0, L_ALT);
		ledchk(1, L_ALT);
		dev = 7'h50;
		ledchk(0, L_GRN);
		dev = 7'h40;
		ledchk(0, L_GFL);
		dev = 7'h58;
		ledchk(0, L_RFL);
		dev = 7'h54;
		ledchk(0, L_RED);
		dev = 7'h50;
		net = 5'h00;
		ledchk(1, L_OFF);
		net = 5'h10;
		ledchk(1, L_GRN);
		net = 5'h18;
		ledchk(1, L_GFL);
		net = 5'h1c;
		tick(1);
		net = 5'h18;
		ledchk(1, L_RFL);
		ledchk(1, L_RFL);
		net = 5'h1a;
		tick(1);
		net = 5'h18;
		ledchk(1, L_GFL);
		net = 5'h1c;
		tick(1);
		net = 5'h19;
		ledchk(1, L_RED);
		net = 5'h18;
		ledchk(1, L_RFL);
		pulse_rst();
		ledchk(1, L_GFL);
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task stop_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog well beyond the expected few hundred cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		n_fail = 0;
		n_tests = 0;
		rst = 1'b1;
		asyncErr = '0;
		errReset = 1'b0;
		driveState = 4'h6;
		dev = 7'h00;
		net = 5'h00;
		repeat (4) @(posedge clk);
		#1;
		`CHK("opCode", OP_START, opCode)
		rst = 1'b0;
		tick(2);
		`CHK("lastStopCause", NO_ERROR, lastStopCause)
		t_async();
		t_sync();
		t_hist();
		t_leds();
		stop_test();
	end
endmodule
